//--- rtl/eac_ctrl.sv
// eeprom access control: control, address and data registers with array
//
// Contract
// [RULE1] control bits 7..6 always read zero
// [RULE2] mode selects atomic, erase, write, reserved
// [RULE3] mode writes ignored while prog_en set
// [RULE4] reset clears mode unless programming
// [RULE5] ready irq level while prog_en low
// [RULE6] master_prog_en self-clears after four cycles
// [RULE7] prog_en starts only with master enable
// [RULE8] software unlocks then strobes within four
// [RULE9] software polls prog_en and self_prog_busy first
// [RULE10] no programming during flash self-programming
// [RULE11] hardware clears prog_en when time elapsed
// [RULE12] core stalled two cycles after prog_en
// [RULE13] read_en loads addressed byte into data
// [RULE14] core stalled four cycles after read
// [RULE15] no read, no address change while writing
// [RULE16] write time counted in rc cycles
// [RULE17] reset lets write in flight finish
// [RULE18] software keeps interrupts off during access
// [RULE19] twelve-bit address, upper bits read zero
// [RULE20] data register feeds writes, receives reads
// [RULE21] reserved mode strobe is no operation
// [RULE22] read during write dropped, read_en clears
`timescale 1ns/1ps
`default_nettype none
module eac_ctrl
    import eac_pkg::*;
#(
    parameter int ATOMIC_CYC = eac_pkg::ATOMIC_RC_CYC,
    parameter int SPLIT_CYC = eac_pkg::SPLIT_RC_CYC,
    parameter int DEPTH = 4096
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // calibrated rc oscillator
    input wire logic rc_osc,
    // core register writes
    input wire logic ctrl_wr,
    input wire logic addr_lo_wr,
    input wire logic addr_hi_wr,
    input wire logic data_wr,
    input wire logic [eac_pkg::DATA_W-1:0] wdata,
    // core register read values
    output logic [eac_pkg::DATA_W-1:0] ctrl_rdata,
    output logic [eac_pkg::DATA_W-1:0] addr_lo_rdata,
    output logic [eac_pkg::DATA_W-1:0] addr_hi_rdata,
    output logic [eac_pkg::DATA_W-1:0] data_rdata,
    // core status and control
    input wire logic global_irq_en,
    input wire logic self_prog_busy,
    output logic ready_irq,
    output logic core_stall
);
    import eac_pkg::*;

    typedef struct packed {
        logic [1:0] mode;
        logic rie;
        logic mpe;
        logic [2:0] mpe_cnt;
        logic pe;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] pdata;
        logic [ADDR_W-1:0] paddr;
        logic [1:0] pmode;
        logic [2:0] stall_cnt;
        logic stall;
        logic irq;
        logic [DATA_W-1:0] ctrl_rd;
    } eac_state_t;

    eac_state_t st_q, st_d;
    logic [DATA_W-1:0] mem [DEPTH];
    logic [RC_CNT_W-1:0] tmr_len;
    logic tmr_start;
    logic tmr_busy;
    logic tmr_done;
    logic do_read;
    logic [1:0] wr_mode;

    // ==============================================================
    // programming time per mode
    function automatic logic [RC_CNT_W-1:0] prog_len(input logic [1:0] m);
        if (m == EAC_MODE_ATOMIC) begin
            prog_len = RC_CNT_W'(ATOMIC_CYC);
        end else begin
            prog_len = RC_CNT_W'(SPLIT_CYC);
        end
    endfunction : prog_len

    // ==============================================================
    // new byte for the array from mode, old byte and data
    function automatic logic [DATA_W-1:0] prog_byte(input logic [1:0] m,
                                                   input logic [DATA_W-1:0] old,
                                                   input logic [DATA_W-1:0] d);
        case (m)
            EAC_MODE_ATOMIC: prog_byte = d;
            EAC_MODE_ERASE: prog_byte = ERASED_BYTE;
            EAC_MODE_WRITE: prog_byte = old & d;
            default: prog_byte = old;
        endcase
    endfunction : prog_byte

    // ==============================================================
    // next state
    always_comb begin
        st_d = st_q;
        tmr_start = 1'b0;
        do_read = 1'b0;
        wr_mode = st_q.pe ? st_q.mode : wdata[CTL_MODE_HI:CTL_MODE_LO]; // RULE3
        // unlock window countdown
        if (st_q.mpe) begin
            st_d.mpe_cnt = st_q.mpe_cnt - 1'b1;
            if (st_q.mpe_cnt <= 3'h1) begin
                st_d.mpe = 1'b0; // RULE6
            end
        end
        // stall countdown
        if (st_q.stall_cnt != 3'h0) begin
            st_d.stall_cnt = st_q.stall_cnt - 1'b1;
        end
        if (ctrl_wr) begin
            st_d.mode = wr_mode; // RULE3
            st_d.rie = wdata[CTL_READY_IRQ_EN];
            if (wdata[CTL_MASTER_PROG_EN] && !wdata[CTL_PROG_EN]) begin
                st_d.mpe = 1'b1;
                st_d.mpe_cnt = MPE_WINDOW_CYC; // RULE6
            end
            // write strobe: needs unlock, idle, no flash work, valid mode
            if (wdata[CTL_PROG_EN] && st_q.mpe && !st_q.pe && !tmr_busy // RULE7
                && !self_prog_busy // RULE10
                && wr_mode != EAC_MODE_RSVD) begin // RULE21
                st_d.pe = 1'b1;
                st_d.mpe = 1'b0;
                st_d.paddr = st_q.addr;
                st_d.pdata = st_q.data; // RULE20
                st_d.pmode = wr_mode; // RULE2
                tmr_start = 1'b1; // RULE16
                st_d.stall_cnt = STALL_WR_CYC; // RULE12
            end else if (wdata[CTL_READ_EN] && !st_q.pe) begin
                do_read = 1'b1; // RULE13 RULE22
                st_d.data = mem[st_q.addr]; // RULE20
                st_d.stall_cnt = STALL_RD_CYC; // RULE14
            end
        end
        // address frozen while a write runs
        if (addr_lo_wr && !st_q.pe) begin
            st_d.addr[DATA_W-1:0] = wdata; // RULE15
        end
        if (addr_hi_wr && !st_q.pe) begin
            st_d.addr[ADDR_W-1:DATA_W] = wdata[ADDR_HI_W-1:0]; // RULE15 RULE19
        end
        if (data_wr && !do_read) begin
            st_d.data = wdata;
        end
        // end of programming
        if (tmr_done) begin
            st_d.pe = 1'b0; // RULE11
        end
        // reset: a write in flight keeps its state
        if (srst) begin
            st_d.rie = 1'b0;
            st_d.mpe = 1'b0;
            st_d.mpe_cnt = 3'h0;
            st_d.stall_cnt = 3'h0;
            // an unknown busy flag at power-up falls into the clearing branch
            if (st_q.pe) begin
                st_d.pmode = st_q.pmode; // RULE17
            end else begin
                st_d.mode = EAC_MODE_ATOMIC; // RULE4
                st_d.pe = 1'b0;
                st_d.addr = ADDR_RST;
                st_d.data = DATA_RST;
                st_d.pdata = DATA_RST;
                st_d.paddr = ADDR_RST;
                st_d.pmode = EAC_MODE_ATOMIC;
            end
        end
        st_d.stall = st_d.stall_cnt != 3'h0;
        st_d.irq = st_d.rie && global_irq_en && !st_d.pe; // RULE5
        // read_en always reads back zero
        st_d.ctrl_rd = {CTL_RSVD_VAL, st_d.mode, st_d.rie, st_d.mpe, st_d.pe, 1'b0}; // RULE1
    end

    // ==============================================================
    // state register; reset handled in the next-state logic
    always_ff @(posedge clk) begin
        st_q <= st_d;
    end

    // ==============================================================
    // array update when programming time has elapsed
    always_ff @(posedge clk) begin
        if (tmr_done) begin
            mem[st_q.paddr] <= prog_byte(st_q.pmode, mem[st_q.paddr], st_q.pdata);
        end
    end

    assign tmr_len = prog_len(st_d.pmode);

    // ==============================================================
    // rc oscillator programming timer
    eac_rc_timer #(
        .CNT_W(RC_CNT_W)
    ) u_timer (
        .clk(clk),
        .srst(srst),
        .rc_osc(rc_osc),
        .start(tmr_start),
        .length(tmr_len),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // ==============================================================
    // outputs straight from the state register
    assign ctrl_rdata = st_q.ctrl_rd;
    assign addr_lo_rdata = st_q.addr[DATA_W-1:0];
    assign addr_hi_rdata = {{(2*DATA_W-ADDR_W){1'b0}}, st_q.addr[ADDR_W-1:DATA_W]}; // RULE19
    assign data_rdata = st_q.data;
    assign ready_irq = st_q.irq;
    assign core_stall = st_q.stall;
endmodule : eac_ctrl
`default_nettype wire

//--- pkg/eac_pkg.sv
// constants and field layout of the eeprom access control block
package eac_pkg;
    // ==============================================================
    // eeprom_control bit positions
    localparam int CTL_READ_EN = 0;
    localparam int CTL_PROG_EN = 1;
    localparam int CTL_MASTER_PROG_EN = 2;
    localparam int CTL_READY_IRQ_EN = 3;
    localparam int CTL_MODE_LO = 4;
    localparam int CTL_MODE_HI = 5;
    localparam logic [1:0] CTL_RSVD_VAL = 2'h0; // bits 7..6 read as zero

    // ==============================================================
    // program modes
    typedef enum logic [1:0] {
        EAC_MODE_ATOMIC = 2'b00,
        EAC_MODE_ERASE = 2'b01,
        EAC_MODE_WRITE = 2'b10,
        EAC_MODE_RSVD = 2'b11
    } eac_mode_t;

    // ==============================================================
    // widths and reset values
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;
    localparam int ADDR_HI_W = ADDR_W - DATA_W;

    // ==============================================================
    // timing
    localparam logic [2:0] MPE_WINDOW_CYC = 3'h4; // unlock lifetime
    localparam logic [2:0] STALL_WR_CYC = 3'h2;
    localparam logic [2:0] STALL_RD_CYC = 3'h4;
    localparam int ATOMIC_TIME_US = 3400;
    localparam int SPLIT_TIME_US = 1800;
    localparam int ATOMIC_RC_CYC = 26368;
    localparam int SPLIT_RC_CYC = ATOMIC_RC_CYC * SPLIT_TIME_US / ATOMIC_TIME_US;
    localparam int RC_CNT_W = 16;
endpackage : eac_pkg

//--- rtl/eac_rc_timer.sv
// programming timer counting calibrated rc oscillator edges
`timescale 1ns/1ps
`default_nettype none
module eac_rc_timer #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // rc oscillator pin, asynchronous to clk
    input wire logic rc_osc,
    // control
    input wire logic start,
    input wire logic [CNT_W-1:0] length,
    output logic busy,
    output logic done
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic busy;
        logic done;
        logic [CNT_W-1:0] cnt;
    } eac_tmr_t;

    eac_tmr_t st_q, st_d;

    // ==============================================================
    // next state: sync, rising edge detect, countdown
    always_comb begin
        st_d = st_q;
        st_d.s1 = rc_osc;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.done = 1'b0;
        if (start && !st_q.busy) begin
            st_d.busy = 1'b1;
            st_d.cnt = length;
        end else if (st_q.busy && st_q.s2 && !st_q.s3) begin
            st_d.cnt = st_q.cnt - 1'b1;
            if (st_q.cnt <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                st_d.busy = 1'b0;
                st_d.done = 1'b1;
            end
        end
    end

    // ==============================================================
    // a reset does not stop a running count
    always_ff @(posedge clk) begin
        if (srst) begin
            // an unknown busy flag at power-up falls into the clearing branch
            if (st_q.busy) begin
                st_q <= st_d;
            end else begin
                st_q <= '0;
            end
        end else begin
            st_q <= st_d;
        end
    end

    assign busy = st_q.busy;
    assign done = st_q.done;
endmodule : eac_rc_timer
`default_nettype wire

//--- test/eac_ctrl_asserts.sv
// port assertions for the eeprom access control block
`timescale 1ns/1ps
`default_nettype none
module eac_ctrl_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // core side
    input wire logic ctrl_wr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] ctrl_rdata,
    input wire logic [7:0] addr_lo_rdata,
    input wire logic [7:0] addr_hi_rdata,
    input wire logic global_irq_en,
    input wire logic self_prog_busy,
    input wire logic ready_irq,
    input wire logic core_stall
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire logic pe = ctrl_rdata[1];
    wire logic irq_ok = ctrl_rdata[3] && global_irq_en && !pe;
    // accepted read and write strobes
    sequence rd_s; ctrl_wr && wdata[0] && !pe; endsequence
    // unlock write: master enable set, strobe bit clear
    sequence unlock_s; ctrl_wr && wdata[2] && !wdata[1]; endsequence
    sequence wr_s;
        ctrl_wr && wdata[1] && !pe && ctrl_rdata[2] && !self_prog_busy && wdata[5:4] != 2'h3;
    endsequence
    rsvd_zero_a: assert property (ctrl_rdata[7:6] == 2'h0)
        else $error("reserved control bits not zero");
    irq_on_a: assert property (irq_ok && $past(irq_ok) |-> ready_irq)
        else $error("ready interrupt missing");
    irq_off_a: assert property (!irq_ok && $past(!irq_ok) |-> !ready_irq)
        else $error("ready interrupt without cause");
    unlock_expiry_a: assert property (unlock_s ##1 !ctrl_wr [*4] |-> ctrl_rdata[2] ##1 !ctrl_rdata[2])
        else $error("master enable outlived its window");
    read_stall_a: assert property (rd_s |=> core_stall [*4] ##1 !core_stall)
        else $error("read stall length wrong");
    write_start_a: assert property (wr_s |=> pe && core_stall ##1 core_stall ##1 !core_stall)
        else $error("write start or its stall wrong");
    start_refused_a: assert property (ctrl_wr && wdata[1] && !pe && (!ctrl_rdata[2] ||
        self_prog_busy || wdata[5:4] == 2'h3) |=> !pe && !core_stall)
        else $error("refused strobe started a write");
    mode_hold_a: assert property (pe && $past(pe) |-> $stable(ctrl_rdata[5:4]))
        else $error("mode changed while programming");
    addr_hold_a: assert property (pe && $past(pe) |-> $stable({addr_hi_rdata, addr_lo_rdata}))
        else $error("address changed while programming");
endmodule : eac_ctrl_asserts
bind eac_ctrl eac_ctrl_asserts chk (.clk, .srst, .ctrl_wr, .wdata, .ctrl_rdata, .addr_lo_rdata,
    .addr_hi_rdata, .global_irq_en, .self_prog_busy, .ready_irq, .core_stall);
`default_nettype wire

//--- test/eac_core_model.sv
// processor core model: register strobes, status levels, rc oscillator
`timescale 1ns/1ps
`default_nettype none
module eac_core_model (
    // clock and readback
    input wire logic clk,
    input wire logic [7:0] ctrl_rdata,
    // strobes and status
    output logic rc_osc = 1'b0,
    output logic ctrl_wr = 1'b0,
    output logic addr_lo_wr = 1'b0,
    output logic addr_hi_wr = 1'b0,
    output logic data_wr = 1'b0,
    output logic [7:0] wdata = 8'h00,
    output logic global_irq_en = 1'b0,
    output logic self_prog_busy = 1'b0
);
    // free running rc oscillator, four core clocks per half period
    always #20 rc_osc = ~rc_osc;
    // one register write; bus shows inverted data once released
    task automatic put(input int sel, input logic [7:0] d);
        @(posedge clk);
        ctrl_wr <= sel == 0;
        addr_lo_wr <= sel == 1;
        addr_hi_wr <= sel == 2;
        data_wr <= sel == 3;
        wdata <= d;
        @(posedge clk);
        {ctrl_wr, addr_lo_wr, addr_hi_wr, data_wr} <= 4'h0;
        wdata <= ~d;
        #1;
    endtask : put
    // write sequence with interrupts held off by the caller
    task automatic wr_byte(input logic [11:0] a, input logic [7:0] d, input logic [1:0] m);
        while (ctrl_rdata[1] !== 1'b0 || self_prog_busy) @(posedge clk);
        put(2, {4'h0, a[11:8]});
        put(1, a[7:0]);
        put(3, d);
        put(0, {2'h0, m, 4'h4});
        put(0, {2'h0, m, 4'h2});
    endtask : wr_byte
endmodule : eac_core_model
`default_nettype wire

//--- test/eeprom_access_control_tb_top.sv
// self-checking bench for the eeprom access control block
`timescale 1ns/1ps
`default_nettype none
module eeprom_access_control_tb_top;
    localparam int ACYC = 20;
    localparam int SCYC = 10;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic rc_osc, ctrl_wr, addr_lo_wr, addr_hi_wr, data_wr, global_irq_en, self_prog_busy;
    logic ready_irq, core_stall;
    logic [7:0] wdata, ctrl_rdata, addr_lo_rdata, addr_hi_rdata, data_rdata;
    int fails = 0;
    int cmp_count = 0;
    always #2.5 clk = ~clk;
    eac_core_model core (.clk, .ctrl_rdata, .rc_osc, .ctrl_wr, .addr_lo_wr, .addr_hi_wr,
        .data_wr, .wdata, .global_irq_en, .self_prog_busy);
    eac_ctrl #(.ATOMIC_CYC(ACYC), .SPLIT_CYC(SCYC)) uut (.clk, .srst, .rc_osc, .ctrl_wr,
        .addr_lo_wr, .addr_hi_wr, .data_wr, .wdata, .ctrl_rdata, .addr_lo_rdata,
        .addr_hi_rdata, .data_rdata, .global_irq_en, .self_prog_busy, .ready_irq, .core_stall);
    // ==============================================================
    // helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_done(output int n);
        n = 0;
        while (ctrl_rdata[1] !== 1'b0 && n < 2000) begin
            @(posedge clk) #1;
            n++;
        end
    endtask : wait_done
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        core.put(2, {4'h0, a[11:8]});
        core.put(1, a[7:0]);
        core.put(0, 8'h01);
        chk(data_rdata, exp);
        repeat (4) @(posedge clk);
    endtask : rd
    task automatic results();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    // ==============================================================
    // scenarios
    task automatic t_reset();
        chk(ctrl_rdata, 8'h00);
        chk(data_rdata, 8'h00);
        core.put(2, 8'hff);
        chk(addr_hi_rdata, 8'h0f);
        $display("test reset done");
    endtask : t_reset
    task automatic t_modes();
        logic [1:0] md [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
        logic [7:0] dv [4] = '{8'ha5, 8'h00, 8'h3c, 8'h0f};
        logic [7:0] ev [4] = '{8'ha5, 8'hff, 8'h3c, 8'h0c};
        int n;
        int c;
        for (int i = 0; i < 4; i++) begin
            c = (md[i] == 2'h0) ? ACYC : SCYC;
            core.wr_byte(12'h5a3, dv[i], md[i]);
            wait_done(n);
            chk(8'(n >= c * 8 - 8 && n <= c * 8 + 16), 8'h01);
            rd(12'h5a3, ev[i]);
        end
        $display("test modes done");
    endtask : t_modes
    task automatic t_refuse();
        core.put(0, 8'h02);
        chk(ctrl_rdata, 8'h00);
        core.put(0, 8'h04);
        chk(ctrl_rdata, 8'h04);
        repeat (5) @(posedge clk);
        core.put(0, 8'h02);
        chk(ctrl_rdata, 8'h00);
        core.self_prog_busy <= 1'b1;
        core.put(0, 8'h04);
        core.put(0, 8'h02);
        chk(ctrl_rdata, 8'h04);
        core.self_prog_busy <= 1'b0;
        core.put(0, 8'h34);
        core.put(0, 8'h32);
        chk(ctrl_rdata, 8'h34);
        rd(12'h5a3, 8'h0c);
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_busy();
        int n;
        core.wr_byte(12'h5a3, 8'h77, 2'h2);
        core.global_irq_en <= 1'b1;
        core.put(0, 8'h38);
        chk(ctrl_rdata, 8'h2a);
        chk({7'h0, ready_irq}, 8'h00);
        core.put(1, 8'h00);
        chk(addr_lo_rdata, 8'ha3);
        core.put(0, 8'h09);
        chk(data_rdata, 8'h77);
        chk(ctrl_rdata, 8'h2a);
        @(posedge clk) srst <= 1'b1;
        @(posedge clk) srst <= 1'b0;
        @(posedge clk) #1;
        chk(ctrl_rdata, 8'h22);
        wait_done(n);
        core.put(0, 8'h08);
        repeat (2) @(posedge clk) #1;
        chk({7'h0, ready_irq}, 8'h01);
        core.put(0, 8'h00);
        repeat (2) @(posedge clk) #1;
        chk({7'h0, ready_irq}, 8'h00);
        core.global_irq_en <= 1'b0;
        rd(12'h5a3, 8'h04);
        $display("test busy done");
    endtask : t_busy
    // ==============================================================
    // main sequence and watchdog
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk) #1;
        t_reset();
        t_modes();
        t_refuse();
        t_busy();
        results();
    end
    initial begin
        #50000;
        fails++;
        results();
    end
endmodule : eeprom_access_control_tb_top
`default_nettype wire
